//--- clmb_pkg.sv
package clmb_pkg;

   // ==========================================================
   // memory map and reset values
   localparam logic [7:0] SP_RST = 8'h07;
   localparam logic [7:0] BIT_BASE = 8'h20;
   localparam logic [7:0] BIT_LAST = 8'h2f;
   localparam int RAM_WORDS = 128;
   localparam int CLK_PERIOD_NS = 50;

   // ==========================================================
   // operations; everything from OP_BIT_ZERO on names a bit
   typedef enum logic [5:0] {
      OP_AND_LOGIC, OP_OR_LOGIC, OP_XOR_LOGIC, OP_XFER,
      OP_SWAP_ACC, OP_LOW_SWAP, OP_ACC_ZERO, OP_ACC_INV,
      OP_ROT_L, OP_ROT_LC, OP_ROT_R, OP_ROT_RC, OP_NIB_SWAP,
      OP_DP_LOAD, OP_CODE_DP, OP_CODE_PROG, OP_XD_RD, OP_XD_WR,
      OP_PUSH, OP_POP, OP_CY_ZERO, OP_CY_ONE, OP_CY_INV,
      OP_BR_CY, OP_BR_NCY, OP_BIT_ZERO, OP_BIT_ONE, OP_BIT_INV,
      OP_CY_AND, OP_CY_ANDN, OP_CY_OR, OP_CY_ORN,
      OP_CY_FROM_BIT, OP_BIT_FROM_CY,
      OP_BR_BIT, OP_BR_NBIT, OP_BR_BIT_CLR
   } clmb_op_e;

   // operand addressing: M_IND is pointer_register, M_DP data_pointer
   typedef enum logic [2:0] {
      M_ACC, M_REG, M_DIR, M_IND, M_IMM, M_DP
   } clmb_mode_e;

   // ==========================================================
   // carriers
   typedef struct packed {
      clmb_op_e op;
      clmb_mode_e dst;
      clmb_mode_e src;
      logic [2:0] rsel;
      logic [7:0] dir_a;
      logic [7:0] dir_b;
      logic [7:0] imm;
      logic [7:0] imm_hi;
      logic [7:0] bit_a;
      logic [7:0] rel;
   } clmb_instr_s;

   typedef struct packed {
      logic re;
      logic we;
      logic [15:0] raddr;
      logic [15:0] waddr;
      logic [7:0] wdata;
   } clmb_mem_s;

   typedef struct packed {
      logic [1:0] len;
      logic [2:0] cyc;
      logic bad;
   } clmb_cost_s;

endpackage

//--- clmb_alu.sv
module clmb_alu (
   input clmb_pkg::clmb_op_e op,
   input wire logic [7:0] acc,
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic cy_in,
   input wire logic bit_in,
   output logic [7:0] res,
   output logic cy_out
);
   import clmb_pkg::*;

   logic [7:0] and_v;
   logic [7:0] or_v;
   logic [7:0] xor_v;

   // ==========================================================
   // byte logic, one cell per bit position
   for (genvar i = 0; i < 8; i++) begin : g_bit
      assign and_v[i] = a[i] & b[i];
      assign or_v[i] = a[i] | b[i];
      assign xor_v[i] = a[i] ^ b[i];
   end

   // ==========================================================
   // result select
   always_comb begin
      res = a;
      cy_out = cy_in;
      case (op)
         OP_AND_LOGIC: res = and_v;
         OP_OR_LOGIC: res = or_v;
         OP_XOR_LOGIC: res = xor_v;
         OP_XFER: res = b;
         OP_ACC_ZERO: res = 8'h00;
         OP_ACC_INV: res = ~acc;
         OP_ROT_L: res = {acc[6:0], acc[7]};
         OP_ROT_R: res = {acc[0], acc[7:1]};
         OP_ROT_LC: begin
            res = {acc[6:0], cy_in};
            cy_out = acc[7];
         end
         OP_ROT_RC: begin
            res = {cy_in, acc[7:1]};
            cy_out = acc[0];
         end
         OP_NIB_SWAP: res = {acc[3:0], acc[7:4]};
         OP_CY_ZERO: cy_out = 1'b0;
         OP_CY_ONE: cy_out = 1'b1;
         OP_CY_INV: cy_out = ~cy_in;
         OP_CY_AND: cy_out = cy_in & bit_in;
         OP_CY_ANDN: cy_out = cy_in & ~bit_in;
         OP_CY_OR: cy_out = cy_in | bit_in;
         OP_CY_ORN: cy_out = cy_in | ~bit_in;
         OP_CY_FROM_BIT: cy_out = bit_in;
         default: res = a;
      endcase
   end

endmodule // clmb_alu

//--- clmb_core.sv
// Contract
// - AND, OR and XOR of bytes work on each bit position independently.
// - logic into accumulator: register 1/1, direct 2/2, indirect 1/2, immediate 2/2.
// - logic into direct byte: from accumulator 2/3, from immediate 3/3.
// - accumulator clear, complement and all rotates are one byte, one cycle.
// - nibble exchange swaps accumulator halves, one byte, one cycle.
// - core moves reach RAM or SFRs by direct, indirect, register, immediate.
// - external RAM moves only to or from the accumulator, indirect only.
// - table lookups only read program memory with indexed addressing.
// - moves into accumulator: register 1/1, direct 2/2, indirect 1/2, immediate 2/2.
// - moves into bank register: accumulator 1/1, direct 2/3, immediate 2/2.
// - moves into direct: acc/register 2/2, direct 3/3, indirect 2/3, immediate 3/3.
// - moves into indirect RAM: accumulator 1/2, direct 2/3, immediate 2/2.
// - loading the data pointer with a 16-bit constant is 3 bytes, 3 cycles.
// - code read indexed by accumulator is one byte; 5 cycles pointer, 4 counter.
// - external reads 4 cycles 8-bit, 3 cycles 16-bit; writes 5 and 4.
// - push of a direct byte is 2/3, pop is 2/2.
// - accumulator exchange: register 1/2, direct 2/3, indirect 1/3.
// - low-digit exchange swaps low nibbles with indirect RAM, 1 byte, 3 cycles.
// - 128 bit-addressable RAM bits plus bit-addressable SFRs serve bit operations.
// - carry clear/set/complement 1/1; same on a direct bit 2/3.
// - AND/OR bit or complement into carry 2/2, bit to carry 2/2, carry to bit 2/3.
// - carry branches 2/3; bit branches 3/5; test-and-clear clears a set bit.
// - indirect addresses come from pointer registers (8-bit) or data pointer (16-bit).
// - direct addresses are 8-bit and reach only internal RAM and SFRs.
module clmb_core (
   input wire logic clock,
   input wire logic srst,
   input wire logic ce,
   input wire logic issue_valid,
   output logic issue_ready,
   input clmb_pkg::clmb_instr_s instr,
   input wire logic [15:0] prog_next,
   output clmb_pkg::clmb_mem_s sfr_bus,
   input wire logic [7:0] sfr_rdata,
   output clmb_pkg::clmb_mem_s xram_bus,
   input wire logic [7:0] xram_rdata,
   output logic code_rd,
   output logic [15:0] code_addr,
   input wire logic [7:0] code_rdata,
   output logic done,
   output logic bad_op,
   output logic [1:0] instr_len,
   output logic branch_take,
   output logic [7:0] branch_rel,
   output logic [7:0] acc,
   output logic carry
);
   import clmb_pkg::*;

   // ==========================================================
   // cost table: bytes and cycles per form
   function automatic clmb_cost_s mk(input logic [1:0] l,
                                     input logic [2:0] c);
      return '{len: l, cyc: c, bad: 1'b0};
   endfunction

   function automatic clmb_cost_s cost_of(input clmb_instr_s i);
      clmb_cost_s c;
      c = '{len: 2'h1, cyc: 3'h1, bad: 1'b1};
      case (i.op)
         OP_AND_LOGIC, OP_OR_LOGIC, OP_XOR_LOGIC, OP_XFER: begin
            if (i.dst == M_ACC) begin
               case (i.src)
                  M_REG: c = mk(2'h1, 3'h1);
                  M_DIR: c = mk(2'h2, 3'h2);
                  M_IND: c = mk(2'h1, 3'h2);
                  M_IMM: c = mk(2'h2, 3'h2);
                  default: c.bad = 1'b1;
               endcase
            end else if (i.op != OP_XFER) begin
               if (i.dst == M_DIR && i.src == M_ACC)
                  c = mk(2'h2, 3'h3);
               if (i.dst == M_DIR && i.src == M_IMM)
                  c = mk(2'h3, 3'h3);
            end else begin
               case ({i.dst, i.src})
                  {M_REG, M_ACC}: c = mk(2'h1, 3'h1);
                  {M_REG, M_DIR}: c = mk(2'h2, 3'h3);
                  {M_REG, M_IMM}: c = mk(2'h2, 3'h2);
                  {M_DIR, M_ACC}: c = mk(2'h2, 3'h2);
                  {M_DIR, M_REG}: c = mk(2'h2, 3'h2);
                  {M_DIR, M_DIR}: c = mk(2'h3, 3'h3);
                  {M_DIR, M_IND}: c = mk(2'h2, 3'h3);
                  {M_DIR, M_IMM}: c = mk(2'h3, 3'h3);
                  {M_IND, M_ACC}: c = mk(2'h1, 3'h2);
                  {M_IND, M_DIR}: c = mk(2'h2, 3'h3);
                  {M_IND, M_IMM}: c = mk(2'h2, 3'h2);
                  default: c.bad = 1'b1;
               endcase
            end
         end
         OP_SWAP_ACC: begin
            case (i.src)
               M_REG: c = mk(2'h1, 3'h2);
               M_DIR: c = mk(2'h2, 3'h3);
               M_IND: c = mk(2'h1, 3'h3);
               default: c.bad = 1'b1;
            endcase
         end
         OP_LOW_SWAP: c = mk(2'h1, 3'h3);
         OP_ACC_ZERO, OP_ACC_INV, OP_ROT_L, OP_ROT_LC, OP_ROT_R,
         OP_ROT_RC: c = mk(2'h1, 3'h1);
         OP_NIB_SWAP: c = mk(2'h1, 3'h1);
         OP_DP_LOAD: c = mk(2'h3, 3'h3);
         OP_CODE_DP: c = mk(2'h1, 3'h5);
         OP_CODE_PROG: c = mk(2'h1, 3'h4);
         OP_XD_RD: begin
            if (i.src == M_IND)
               c = mk(2'h1, 3'h4);
            if (i.src == M_DP)
               c = mk(2'h1, 3'h3);
         end
         OP_XD_WR: begin
            if (i.dst == M_IND)
               c = mk(2'h1, 3'h5);
            if (i.dst == M_DP)
               c = mk(2'h1, 3'h4);
         end
         OP_PUSH: c = mk(2'h2, 3'h3);
         OP_POP: c = mk(2'h2, 3'h2);
         OP_CY_ZERO, OP_CY_ONE, OP_CY_INV: c = mk(2'h1, 3'h1);
         OP_BIT_ZERO, OP_BIT_ONE, OP_BIT_INV: c = mk(2'h2, 3'h3);
         OP_CY_AND, OP_CY_ANDN, OP_CY_OR, OP_CY_ORN,
         OP_CY_FROM_BIT: c = mk(2'h2, 3'h2);
         OP_BIT_FROM_CY: c = mk(2'h2, 3'h3);
         OP_BR_CY, OP_BR_NCY: c = mk(2'h2, 3'h3);
         OP_BR_BIT, OP_BR_NBIT,
         OP_BR_BIT_CLR: c = mk(2'h3, 3'h5);
         default: c.bad = 1'b1;
      endcase
      return c;
   endfunction

   function automatic logic [7:0] pick(input clmb_mode_e m,
                                       input logic [7:0] av,
                                       input logic [7:0] rv,
                                       input logic [7:0] dv,
                                       input logic [7:0] iv,
                                       input logic [7:0] xv);
      case (m)
         M_ACC: return av;
         M_REG: return rv;
         M_DIR: return dv;
         M_IND: return iv;
         M_IMM: return xv;
         default: return 8'h00;
      endcase
   endfunction

   // ==========================================================
   // state
   clmb_instr_s ir_r;
   logic [2:0] cnt_r;
   logic [15:0] pc_r;
   logic [7:0] acc_r;
   logic cy_r;
   logic [15:0] dp_r;
   logic [7:0] sp_r;
   logic [7:0] ram_r [RAM_WORDS];

   clmb_cost_s cost_i;
   clmb_cost_s cost_r;
   logic accept;
   logic busy;
   logic commit;
   logic go;
   logic is_lg;
   logic is_mv;
   logic is_bitop;
   logic [7:0] ri_val;
   logic [6:0] ri_ptr;
   logic [7:0] reg_v;
   logic [7:0] ind_v;
   logic [7:0] rd_dir;
   logic [7:0] bit_byte;
   logic [7:0] rd_addr;
   logic [7:0] rd_v;
   logic bit_v;
   logic [7:0] src_v;
   logic [7:0] dst_v;
   logic [7:0] alu_res;
   logic alu_cy;
   clmb_mode_e tgt;
   logic [7:0] tgt_addr;
   logic [7:0] sp_up;
   logic [7:0] bit_mask;
   logic bit_new;
   logic [7:0] bit_byte_nxt;
   logic need_rd;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_val;
   logic acc_we;
   logic [7:0] acc_nxt;
   logic cy_we;
   logic br_cond;
   clmb_mode_e xd_mode;

   // ==========================================================
   // sequencing
   assign cost_i = cost_of(instr);
   assign cost_r = cost_of(ir_r);
   assign busy = (cnt_r != 3'h0);
   assign issue_ready = ~busy;
   assign accept = ce & issue_valid & ~busy;
   assign commit = ce & (cnt_r == 3'h1);
   // a bad form still takes its cycle but changes nothing
   assign go = commit & ~cost_r.bad;

   // ==========================================================
   // operand fetch
   assign is_lg = ir_r.op inside {OP_AND_LOGIC, OP_OR_LOGIC, OP_XOR_LOGIC};
   assign is_mv = is_lg | (ir_r.op == OP_XFER);
   assign is_bitop = ir_r.op inside {[OP_BIT_ZERO:OP_BR_BIT_CLR]};
   // only bank 0 is reachable; bank select lives outside
   assign ri_val = ram_r[{6'h00, ir_r.rsel[0]}];
   // upper 128 bytes are not fitted, so the pointer drops bit 7
   assign ri_ptr = ri_val[6:0];
   assign reg_v = ram_r[{4'h0, ir_r.rsel}];
   assign ind_v = ram_r[ri_ptr];
   assign rd_dir = (is_mv && ir_r.dst == M_DIR && ir_r.src == M_DIR) ?
                   ir_r.dir_b : ir_r.dir_a;
   assign bit_byte = ir_r.bit_a[7] ? {ir_r.bit_a[7:3], 3'h0} :
                     8'(BIT_BASE + {4'h0, ir_r.bit_a[6:3]});
   assign rd_addr = is_bitop ? bit_byte : rd_dir;
   assign rd_v = rd_addr[7] ? sfr_rdata : ram_r[rd_addr[6:0]];
   assign bit_v = rd_v[ir_r.bit_a[2:0]];
   assign src_v = pick(ir_r.src, acc_r, reg_v, rd_v, ind_v, ir_r.imm);
   assign dst_v = pick(ir_r.dst, acc_r, reg_v, rd_v, ind_v, ir_r.imm);

   clmb_alu u_alu (
      .op(ir_r.op),
      .acc(acc_r),
      .a(dst_v),
      .b(src_v),
      .cy_in(cy_r),
      .bit_in(bit_v),
      .res(alu_res),
      .cy_out(alu_cy)
   );

   // ==========================================================
   // write-back target
   assign tgt = (ir_r.op == OP_SWAP_ACC) ? ir_r.src : ir_r.dst;
   assign tgt_addr = (tgt == M_REG) ? {5'h00, ir_r.rsel} :
                     (tgt == M_IND) ? {1'b0, ri_ptr} : ir_r.dir_a;
   assign sp_up = sp_r + 8'h01;
   assign bit_mask = 8'h01 << ir_r.bit_a[2:0];
   assign bit_new = (ir_r.op == OP_BIT_ONE) |
                    ((ir_r.op == OP_BIT_INV) & ~bit_v) |
                    ((ir_r.op == OP_BIT_FROM_CY) & cy_r);
   assign bit_byte_nxt = bit_new ? (rd_v | bit_mask) : (rd_v & ~bit_mask);

   always_comb begin
      wr_en = 1'b0;
      wr_addr = tgt_addr;
      wr_val = alu_res;
      case (ir_r.op)
         OP_AND_LOGIC, OP_OR_LOGIC, OP_XOR_LOGIC,
         OP_XFER: wr_en = (ir_r.dst != M_ACC);
         OP_SWAP_ACC: begin
            wr_en = 1'b1;
            wr_val = acc_r;
         end
         OP_LOW_SWAP: begin
            wr_en = 1'b1;
            wr_addr = {1'b0, ri_ptr};
            wr_val = {ind_v[7:4], acc_r[3:0]};
         end
         OP_PUSH: begin
            wr_en = 1'b1;
            wr_addr = {1'b0, sp_up[6:0]};
            wr_val = rd_v;
         end
         OP_POP: begin
            wr_en = 1'b1;
            wr_addr = ir_r.dir_a;
            wr_val = ram_r[sp_r[6:0]];
         end
         OP_BIT_ZERO, OP_BIT_ONE, OP_BIT_INV, OP_BIT_FROM_CY: begin
            wr_en = 1'b1;
            wr_addr = bit_byte;
            wr_val = bit_byte_nxt;
         end
         OP_BR_BIT_CLR: begin
            wr_en = bit_v;
            wr_addr = bit_byte;
            wr_val = bit_byte_nxt;
         end
         default: wr_en = 1'b0;
      endcase
   end

   always_comb begin
      acc_we = 1'b1;
      acc_nxt = alu_res;
      case (ir_r.op)
         OP_AND_LOGIC, OP_OR_LOGIC, OP_XOR_LOGIC,
         OP_XFER: acc_we = (ir_r.dst == M_ACC);
         OP_SWAP_ACC: acc_nxt = src_v;
         OP_LOW_SWAP: acc_nxt = {acc_r[7:4], ind_v[3:0]};
         OP_ACC_ZERO, OP_ACC_INV, OP_ROT_L, OP_ROT_LC, OP_ROT_R,
         OP_ROT_RC, OP_NIB_SWAP: acc_nxt = alu_res;
         OP_CODE_DP, OP_CODE_PROG: acc_nxt = code_rdata;
         OP_XD_RD: acc_nxt = xram_rdata;
         default: acc_we = 1'b0;
      endcase
   end

   assign cy_we = ir_r.op inside {OP_ROT_LC, OP_ROT_RC, OP_CY_ZERO,
                  OP_CY_ONE, OP_CY_INV, OP_CY_AND, OP_CY_ANDN, OP_CY_OR,
                  OP_CY_ORN, OP_CY_FROM_BIT};

   always_comb begin
      case (ir_r.op)
         OP_BR_CY: br_cond = cy_r;
         OP_BR_NCY: br_cond = ~cy_r;
         OP_BR_BIT, OP_BR_BIT_CLR: br_cond = bit_v;
         OP_BR_NBIT: br_cond = ~bit_v;
         default: br_cond = 1'b0;
      endcase
   end

   // ==========================================================
   // external ports
   assign need_rd = is_bitop | (ir_r.op == OP_PUSH) |
                    ((is_mv | (ir_r.op == OP_SWAP_ACC)) &
                     (ir_r.src == M_DIR)) |
                    (is_lg & (ir_r.dst == M_DIR));
   assign sfr_bus.re = busy & need_rd & rd_addr[7];
   assign sfr_bus.we = go & wr_en & wr_addr[7];
   assign sfr_bus.raddr = {8'h00, rd_addr};
   assign sfr_bus.waddr = {8'h00, wr_addr};
   assign sfr_bus.wdata = wr_val;

   assign xd_mode = (ir_r.op == OP_XD_WR) ? ir_r.dst : ir_r.src;
   assign xram_bus.re = busy & ~cost_r.bad & (ir_r.op == OP_XD_RD);
   assign xram_bus.we = go & (ir_r.op == OP_XD_WR);
   assign xram_bus.raddr = (xd_mode == M_DP) ? dp_r : {8'h00, ri_val};
   assign xram_bus.waddr = xram_bus.raddr;
   assign xram_bus.wdata = acc_r;

   assign code_rd = busy & (ir_r.op inside {OP_CODE_DP, OP_CODE_PROG});
   assign code_addr = ((ir_r.op == OP_CODE_DP) ? dp_r : pc_r) +
                      {8'h00, acc_r};

   assign done = commit;
   assign bad_op = commit & cost_r.bad;
   assign instr_len = cost_r.len;
   assign branch_take = go & br_cond;
   assign branch_rel = ir_r.rel;
   assign acc = acc_r;
   assign carry = cy_r;

   // ==========================================================
   // registers
   always_ff @(posedge clock) begin
      if (srst) begin
         cnt_r <= 3'h0;
         ir_r <= '0;
         pc_r <= 16'h0000;
      end else if (accept) begin
         cnt_r <= cost_i.cyc;
         ir_r <= instr;
         pc_r <= prog_next;
      end else if (ce && busy) begin
         cnt_r <= cnt_r - 3'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         acc_r <= 8'h00;
         cy_r <= 1'b0;
         dp_r <= 16'h0000;
         sp_r <= SP_RST;
      end else if (go) begin
         if (acc_we)
            acc_r <= acc_nxt;
         if (cy_we)
            cy_r <= alu_cy;
         if (ir_r.op == OP_DP_LOAD)
            dp_r <= {ir_r.imm_hi, ir_r.imm};
         if (ir_r.op == OP_PUSH)
            sp_r <= sp_up;
         if (ir_r.op == OP_POP)
            sp_r <= sp_r - 8'h01;
      end
   end

   // data storage, left unreset on purpose
   always_ff @(posedge clock) begin
      if (go && wr_en && !wr_addr[7])
         ram_r[wr_addr[6:0]] <= wr_val;
   end

   // ==========================================================
   // checks
   logic [2:0] age_r;
   logic [3:0] acc_lo;
   logic [3:0] acc_hi;
   logic acc_msb;
   assign acc_lo = acc_r[3:0];
   assign acc_hi = acc_r[7:4];
   assign acc_msb = acc_r[7];

   always_ff @(posedge clock) begin
      if (srst)
         age_r <= 3'h0;
      else if (ce)
         age_r <= accept ? 3'h0 : 3'(age_r + 3'h1);
   end

   default clocking @(posedge clock); endclocking
   default disable iff (srst);

   a_done_count: assert property (
      done |-> (3'(age_r + 3'h1) == cost_r.cyc))
      else $error("done at wrong cycle count");
   a_ready_busy: assert property (
      busy |-> !issue_ready ##0 !accept)
      else $error("accepted while busy");
   a_bitwise_and: assert property (
      go && ir_r.op == OP_AND_LOGIC && ir_r.dst == M_ACC
      |=> acc_r == ($past(acc_r) & $past(src_v)))
      else $error("byte and result wrong");
   a_nibble_swap: assert property (
      go && ir_r.op == OP_NIB_SWAP
      |=> acc_r == {$past(acc_lo), $past(acc_hi)})
      else $error("nibble swap wrong");
   a_rot_carry: assert property (
      go && ir_r.op == OP_ROT_LC
      |=> cy_r == $past(acc_msb) && acc_r[0] == $past(cy_r))
      else $error("rotate through carry wrong");
   a_xram_acc: assert property (
      xram_bus.we |-> ir_r.op == OP_XD_WR && xram_bus.wdata == acc_r)
      else $error("external write not from accumulator");
   a_data_pointer_load: assert property (
      accept && instr.op == OP_DP_LOAD ##1 ce ##1 ce
      |-> ##1 cnt_r == 3'h1 && ir_r.op == OP_DP_LOAD)
      else $error("pointer load not three cycles");
   a_jbc_clear: assert property (
      go && ir_r.op == OP_BR_BIT_CLR && bit_v
      |-> wr_en && branch_take && !bit_byte_nxt[ir_r.bit_a[2:0]])
      else $error("test-and-clear did not clear");
   a_bit_region: assert property (
      go && is_bitop && !ir_r.bit_a[7]
      |-> rd_addr >= BIT_BASE && rd_addr <= BIT_LAST)
      else $error("bit outside bit region");

endmodule // clmb_core

//--- clmb_mem_model.sv
module clmb_mem_model (
   input wire logic clock,
   input clmb_pkg::clmb_mem_s sfr_bus,
   input clmb_pkg::clmb_mem_s xram_bus,
   input wire logic code_rd,
   input wire logic [15:0] code_addr,
   output logic [7:0] sfr_rdata,
   output logic [7:0] xram_rdata,
   output logic [7:0] code_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] sfr_m [128];
   logic [7:0] xd_m [256];
   wire [7:0] sv = sfr_m[sfr_bus.raddr[6:0]];
   wire [7:0] xv = xd_m[xram_bus.raddr[7:0]];
   wire [7:0] cv = code_addr[15:8] + code_addr[7:0];
   // ==========================================
   // idle reads show the inverse so a stale byte never passes
   assign sfr_rdata = sfr_bus.re ? sv : ~sv;
   assign xram_rdata = xram_bus.re ? xv : ~xv;
   assign code_rdata = code_rd ? cv : ~cv;
   always_ff @(posedge clock) begin
      if (sfr_bus.we) sfr_m[sfr_bus.waddr[6:0]] <= sfr_bus.wdata;
      if (xram_bus.we) xd_m[xram_bus.waddr[7:0]] <= xram_bus.wdata;
   end
endmodule // clmb_mem_model

//--- cpu_logic_move_bit_ops_bench.sv
module cpu_logic_move_bit_ops_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import clmb_pkg::*;
   logic clock = 0, srst = 1, ce = 1, issue_valid = 0, issue_ready;
   logic done, bad_op, branch_take, carry, code_rd, bad_s, br_s;
   logic [1:0] instr_len;
   logic [7:0] branch_rel, acc, sfr_rdata, xram_rdata, code_rdata;
   logic [15:0] code_addr, prog_next = 16'h0100;
   clmb_instr_s instr = '0;
   clmb_mem_s sfr_bus, xram_bus;
   int err_total = 0, n_tests = 0;
   always #25 clock = ~clock;
   clmb_core i_dut (.clock(clock), .srst(srst), .ce(ce),
      .issue_valid(issue_valid), .issue_ready(issue_ready),
      .instr(instr), .prog_next(prog_next), .sfr_bus(sfr_bus),
      .sfr_rdata(sfr_rdata), .xram_bus(xram_bus),
      .xram_rdata(xram_rdata), .code_rd(code_rd),
      .code_addr(code_addr), .code_rdata(code_rdata), .done(done),
      .bad_op(bad_op), .instr_len(instr_len),
      .branch_take(branch_take), .branch_rel(branch_rel),
      .acc(acc), .carry(carry));
   clmb_mem_model i_mem (.clock(clock), .sfr_bus(sfr_bus),
      .xram_bus(xram_bus), .code_rd(code_rd), .code_addr(code_addr),
      .sfr_rdata(sfr_rdata), .xram_rdata(xram_rdata),
      .code_rdata(code_rdata));
   // ==========================================
   task automatic chk(input string nm, input logic [15:0] e, g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic clmb_instr_s mk(clmb_op_e o, clmb_mode_e d, s,
      logic [2:0] r, logic [7:0] da, im, hi = 8'h00);
      return '{o, d, s, r, da, 8'h00, im, hi, da, 8'h12};
   endfunction
   // counts ce cycles from accept to done; len < 0 skips the length
   task automatic run(input clmb_instr_s i, input int cyc, len);
      int n;
      @(negedge clock);
      issue_valid = 1;
      instr = i;
      @(negedge clock);
      issue_valid = 0;
      n = 1;
      if (len >= 0) chk("length", len[1:0], {14'h0000, instr_len});
      while (done !== 1'b1 && n < 9) begin
         @(negedge clock);
         n++;
      end
      bad_s = bad_op;
      br_s = branch_take;
      @(negedge clock);
      chk("cycles", cyc[15:0], n[15:0]);
   endtask
   // ==========================================
   task t_logic;
      run(mk(OP_XFER, M_ACC, M_IMM, 0, 0, 8'hc5), 2, 2);
      run(mk(OP_AND_LOGIC, M_ACC, M_IMM, 0, 0, 8'h3c), 2, 2);
      chk("acc", 8'h04, acc);
      run(mk(OP_OR_LOGIC, M_ACC, M_IMM, 0, 0, 8'h30), 2, 2);
      run(mk(OP_XOR_LOGIC, M_ACC, M_IMM, 0, 0, 8'hff), 2, 2);
      chk("acc", 8'hcb, acc);
      run(mk(OP_XFER, M_DIR, M_IMM, 0, 8'h40, 8'h0f), 3, 3);
      run(mk(OP_XOR_LOGIC, M_DIR, M_ACC, 0, 8'h40, 0), 3, 2);
      run(mk(OP_XFER, M_REG, M_ACC, 3, 0, 0), 1, 1);
      run(mk(OP_XFER, M_ACC, M_DIR, 0, 8'h40, 0), 2, 2);
      chk("acc", 8'hc4, acc);
      run(mk(OP_AND_LOGIC, M_ACC, M_REG, 3, 0, 0), 1, 1);
      chk("acc", 8'hc0, acc);
   endtask
   task automatic t_acc;
      clmb_op_e ops[9] = '{OP_ROT_RC, OP_ROT_LC, OP_ROT_R, OP_ROT_L,
         OP_NIB_SWAP, OP_ACC_INV, OP_CY_INV, OP_ROT_RC, OP_ACC_ZERO};
      logic [7:0] ea[9] = '{8'hcb, 8'h96, 8'h4b, 8'h96, 8'h69, 8'h96,
         8'h96, 8'h4b, 8'h00};
      logic ec[9] = '{0, 1, 1, 1, 1, 1, 0, 0, 0};
      run(mk(OP_XFER, M_ACC, M_IMM, 0, 0, 8'h96), 2, 2);
      run(mk(OP_CY_ONE, M_ACC, M_ACC, 0, 0, 0), 1, 1);
      for (int k = 0; k < 9; k++) begin
         run(mk(ops[k], M_ACC, M_ACC, 0, 0, 0), 1, 1);
         chk("acc", ea[k], acc);
         chk("carry", ec[k], carry);
      end
   endtask
   task t_mem;
      run(mk(OP_XFER, M_REG, M_IMM, 0, 0, 8'h50), 2, 2);
      run(mk(OP_XFER, M_IND, M_IMM, 0, 0, 8'h77), 2, 2);
      run(mk(OP_XFER, M_ACC, M_IND, 0, 0, 0), 2, 1);
      chk("acc", 8'h77, acc);
      run(mk(OP_XD_WR, M_IND, M_ACC, 0, 0, 0), 5, 1);
      run(mk(OP_ACC_ZERO, M_ACC, M_ACC, 0, 0, 0), 1, 1);
      run(mk(OP_XD_RD, M_ACC, M_IND, 0, 0, 0), 4, 1);
      chk("acc", 8'h77, acc);
      run(mk(OP_DP_LOAD, M_DP, M_IMM, 0, 0, 8'h34, 8'h12), 3, 3);
      run(mk(OP_XD_WR, M_DP, M_ACC, 0, 0, 0), 4, 1);
      run(mk(OP_XFER, M_ACC, M_IMM, 0, 0, 8'h05), 2, 2);
      run(mk(OP_CODE_DP, M_ACC, M_DP, 0, 0, 0), 5, 1);
      chk("acc", 8'h4b, acc);
      run(mk(OP_CODE_PROG, M_ACC, M_ACC, 0, 0, 0), 4, 1);
      chk("acc", 8'h4c, acc);
      run(mk(OP_XFER, M_DIR, M_IMM, 0, 8'h90, 8'ha5), 3, 3);
      run(mk(OP_XFER, M_ACC, M_DIR, 0, 8'h90, 0), 2, 2);
      chk("acc", 8'ha5, acc);
      run(mk(OP_XD_RD, M_ACC, M_IMM, 0, 0, 0), 1, -1);
      chk("refused", 9'h1a5, {bad_s, acc});
   endtask
   task t_bit;
      run(mk(OP_BIT_ONE, M_ACC, M_ACC, 0, 8'h03, 0), 3, 2);
      run(mk(OP_CY_ZERO, M_ACC, M_ACC, 0, 0, 0), 1, 1);
      run(mk(OP_CY_FROM_BIT, M_ACC, M_ACC, 0, 8'h03, 0), 2, 2);
      chk("carry", 1, carry);
      run(mk(OP_BR_BIT_CLR, M_ACC, M_ACC, 0, 8'h03, 0), 5, 3);
      chk("taken", 1, br_s);
      run(mk(OP_BR_BIT, M_ACC, M_ACC, 0, 8'h03, 0), 5, 3);
      chk("taken", 0, br_s);
      run(mk(OP_CY_ANDN, M_ACC, M_ACC, 0, 8'h03, 0), 2, 2);
      run(mk(OP_BR_CY, M_ACC, M_ACC, 0, 0, 0), 3, 2);
      chk("taken", 1, br_s);
   endtask
   // ==========================================
   task t_xchg;
      run(mk(OP_SWAP_ACC, M_ACC, M_REG, 3, 0, 0), 2, 1);
      chk("acc", 8'hcb, acc);
      run(mk(OP_LOW_SWAP, M_ACC, M_IND, 0, 0, 0), 3, 1);
      chk("acc", 8'hc7, acc);
      run(mk(OP_PUSH, M_ACC, M_DIR, 0, 8'h03, 0), 3, 2);
      run(mk(OP_POP, M_DIR, M_ACC, 0, 8'h41, 0), 2, 2);
      run(mk(OP_XFER, M_ACC, M_DIR, 0, 8'h41, 0), 2, 2);
      chk("acc", 8'ha5, acc);
      run(mk(OP_CY_ZERO, M_ACC, M_ACC, 0, 0, 0), 1, 1);
      run(mk(OP_BIT_INV, M_ACC, M_ACC, 0, 8'h91, 0), 3, 2);
      run(mk(OP_CY_OR, M_ACC, M_ACC, 0, 8'h91, 0), 2, 2);
      run(mk(OP_BR_NCY, M_ACC, M_ACC, 0, 0, 0), 3, 2);
      chk("taken", 0, br_s);
      run(mk(OP_BIT_FROM_CY, M_ACC, M_ACC, 0, 8'h93, 0), 3, 2);
      run(mk(OP_BIT_ZERO, M_ACC, M_ACC, 0, 8'h97, 0), 3, 2);
      run(mk(OP_CY_AND, M_ACC, M_ACC, 0, 8'h97, 0), 2, 2);
      run(mk(OP_CY_ORN, M_ACC, M_ACC, 0, 8'h97, 0), 2, 2);
      run(mk(OP_BR_NBIT, M_ACC, M_ACC, 0, 8'h97, 0), 5, 3);
      chk("taken", 1, br_s);
      chk("rel", 8'h12, branch_rel);
      run(mk(OP_XFER, M_ACC, M_DIR, 0, 8'h90, 0), 2, 2);
      chk("flags", 9'h12f, {carry, acc});
   endtask
   task t_stall;
      @(negedge clock);
      issue_valid = 1;
      instr = mk(OP_XFER, M_ACC, M_IMM, 0, 0, 8'h5a);
      @(negedge clock);
      issue_valid = 0;
      ce = 0;
      repeat (3) @(negedge clock);
      ce = 1;
      @(negedge clock);
      chk("done", 1, done);
      @(negedge clock);
      chk("acc", 8'h5a, acc);
      issue_valid = 1;
      instr = mk(OP_CODE_DP, M_ACC, M_DP, 0, 0, 0);
      @(negedge clock);
      issue_valid = 0;
      srst = 1;
      @(negedge clock);
      srst = 0;
      chk("reset", 10'h200, {issue_ready, carry, acc});
   endtask
   task end_of_test;
      if (err_total == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #(3000 * 50);
      err_total++;
      end_of_test();
   end
   initial begin
      repeat (12) @(posedge clock);
      @(negedge clock);
      srst = 0;
      chk("reset", 10'h200, {issue_ready, carry, acc});
      t_logic();
      t_acc();
      t_mem();
      t_bit();
      t_xchg();
      t_stall();
      end_of_test();
   end
endmodule // cpu_logic_move_bit_ops_bench
